// File: rtl/crf_core_regs.sv
// Architectural register file of the core with an AHB-Lite window on the
// special registers. Assumes core-side inputs are on clk and the bus is
// only used while ce is high.
// Contract
// - Low thirteen registers are plain operand registers
// - Registers zero to seven reachable by all forms
// - Eight to twelve reachable only by wide forms
// - Stack pointer banked; process one for unprivileged thread
// - Stack pointer low two bits read zero
// - Return address captured on subroutine call
// - Program counter bit zero reads zero
// - Status word has three views, separately accessible
// - Flags held in bits 27 to 31
// - Exception number held in bits 0 to 8
// - Execution state in bits 10-15, 25-26
// - Status bit 24 reads one in the whole word and execution view (privileged reads)
// - Clearing bit 24 raises a fault
// - Priority mask allows only NMI and hard fault
// - Fault mask allows only NMI
// - Threshold blocks equal or higher priority values
// - Zero threshold disables masking
// - Handler mode while servicing, thread otherwise
// - Unprivileged special access blocked and faults
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
module crf_core_regs
    import crf_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire crf_rd_s               rd_a,
    input  wire crf_rd_s               rd_b,
    input  wire crf_gwr_s              gwr,
    input  wire logic                  gwr_narrow,
    input  wire logic                  call_en,
    input  wire logic [CRF_XLEN-1:0]   call_ret,
    input  wire logic                  pc_we,
    input  wire logic [CRF_XLEN-1:0]   pc_wdata,
    input  wire logic                  flag_we,
    input  wire logic [4:0]            flag_in,
    input  wire logic                  exc_entry,
    input  wire logic [CRF_EXCN_MSB:0] exc_num,
    input  wire logic                  exc_return,
    input  wire logic                  instr_boundary,
    input  wire logic                  spec_acc,
    input  wire crf_irq_s              irq,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [3:0]            hprot,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [CRF_XLEN-1:0]   rd_a_data,
    output logic      [CRF_XLEN-1:0]   rd_b_data,
    output logic      [CRF_XLEN-1:0]   sp_out,
    output logic      [CRF_XLEN-1:0]   pc_out,
    output logic                       handler_mode,
    output logic                       exc_accept,
    output logic                       fault_pulse,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [31:0]           hrdata
);
    typedef struct packed {
        logic [31:0]           main_stack_ptr;
        logic [31:0]           process_stack_ptr;
        logic [31:0]           lr;
        logic [31:0]           pc;
        logic [4:0]            flags;
        logic [CRF_EXCN_MSB:0] excn;
        logic [5:0]            exlo;
        logic [1:0]            exhi;
        logic                  prim;
        logic                  fltm;
        logic [8:0]            bpri;
        logic                  unpriv;
        logic                  handler;
        logic                  act_prim;
        logic                  act_fltm;
        logic [8:0]            act_bpri;
        logic                  act_psp;
        logic [31:0]           rda;
        logic [31:0]           rdb;
        logic [31:0]           sp;
        logic                  fault;
        logic                  accept;
        logic                  dph_v;
        logic                  dph_wr;
        logic                  dph_priv;
        logic [7:0]            dph_addr;
        logic                  hrdy;
        logic [31:0]           hrd;
    } crf_core_s;

    crf_core_s            st_q;
    crf_core_s            st_d;
    logic [CRF_XLEN-1:0]  bank_a;
    logic [CRF_XLEN-1:0]  bank_b;
    logic                 take;
    logic                 ahb_we;
    logic                 ahb_rd;
    crf_gwr_s             bank_wr;

    // 16-bit forms only carry three index bits
    function automatic logic [CRF_IDX_W-1:0] eff_idx(input logic narrow, input logic [CRF_IDX_W-1:0] idx);
        eff_idx = narrow ? {1'b0, idx[2:0]} : idx;
    endfunction

    function automatic logic [31:0] psw_word(input crf_core_s s);
        logic [31:0] w;
        w = '0;
        w[CRF_FLAG_MSB:CRF_FLAG_LSB] = s.flags;
        w[CRF_EXCN_MSB:0]            = s.excn;
        w[CRF_EXLO_MSB:CRF_EXLO_LSB] = s.exlo;
        w[CRF_EXHI_MSB:CRF_EXHI_LSB] = s.exhi;
        w[CRF_TBIT]                  = 1'b1;
        psw_word = w;
    endfunction

    function automatic logic [31:0] bus_read(input crf_core_s s, input logic [7:0] a);
        bus_read = '0;
        unique case (a)
            CRF_OFF_PSW:   bus_read = psw_word(s);
            CRF_OFF_FLAGS: bus_read = psw_word(s) & CRF_VIEW_FLAGS;
            CRF_OFF_EXCN:  bus_read = psw_word(s) & CRF_VIEW_EXCN;
            CRF_OFF_EXEC:  bus_read = psw_word(s) & CRF_VIEW_EXEC;
            CRF_OFF_PRIM:  bus_read = {31'h0000_0000, s.prim};
            CRF_OFF_FLTM:  bus_read = {31'h0000_0000, s.fltm};
            CRF_OFF_BPRI:  bus_read = {23'h00_0000, s.bpri};
            CRF_OFF_MSP:   bus_read = s.main_stack_ptr;
            CRF_OFF_PSP:   bus_read = s.process_stack_ptr;
            CRF_OFF_CTRL:  bus_read = {30'h0000_0000, s.handler, s.unpriv};
            CRF_OFF_LR:    bus_read = s.lr;
            CRF_OFF_PC:    bus_read = s.pc;
            default:       bus_read = '0;
        endcase
    endfunction

    function automatic logic [31:0] core_read(input crf_core_s s, input logic [CRF_IDX_W-1:0] i,
                                              input logic [31:0] bank);
        if (32'(i) == CRF_IDX_SP)
            core_read = s.act_psp ? s.process_stack_ptr : s.main_stack_ptr;
        else if (32'(i) == CRF_IDX_LR)
            core_read = s.lr;
        else if (32'(i) == CRF_IDX_PC)
            core_read = s.pc;
        else
            core_read = bank;
    endfunction

    always_comb
    begin
        bank_wr     = gwr;
        bank_wr.idx = eff_idx(gwr_narrow, gwr.idx);
    end

    crf_gpr_bank #(
        .NREG (CRF_NGPR),
        .W    (CRF_XLEN)
    ) u_bank (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .wr      (bank_wr),
        .ra_idx  (eff_idx(rd_a.narrow, rd_a.idx)),
        .rb_idx  (eff_idx(rd_b.narrow, rd_b.idx)),
        .ra_data (bank_a),
        .rb_data (bank_b)
    );

    crf_mask_gate u_gate (
        .prim (st_q.act_prim),
        .fltm (st_q.act_fltm),
        .bpri (st_q.act_bpri),
        .irq  (irq),
        .take (take)
    );

    assign ahb_we = st_q.dph_v && st_q.dph_wr && st_q.dph_priv;
    assign ahb_rd = hsel && htrans[1] && hready && !hwrite;

    always_comb
    begin
        st_d        = st_q;
        st_d.fault  = 1'b0;
        st_d.accept = take;
        st_d.rda    = core_read(st_q, eff_idx(rd_a.narrow, rd_a.idx), bank_a);
        st_d.rdb    = core_read(st_q, eff_idx(rd_b.narrow, rd_b.idx), bank_b);
        if (bank_wr.en && (32'(bank_wr.idx) == CRF_IDX_SP))
        begin
            if (st_q.act_psp)
                st_d.process_stack_ptr = bank_wr.data & CRF_SP_MASK;
            else
                st_d.main_stack_ptr = bank_wr.data & CRF_SP_MASK;
        end
        if (bank_wr.en && (32'(bank_wr.idx) == CRF_IDX_LR))
            st_d.lr = bank_wr.data;
        if (bank_wr.en && (32'(bank_wr.idx) == CRF_IDX_PC))
            st_d.pc = bank_wr.data & CRF_PC_MASK;
        if (call_en)
            st_d.lr = call_ret;
        if (pc_we)
            st_d.pc = pc_wdata & CRF_PC_MASK;
        if (flag_we)
            st_d.flags = flag_in;
        if (exc_entry)
        begin
            st_d.handler = 1'b1;
            st_d.excn    = exc_num;
        end
        else if (exc_return)
        begin
            st_d.handler = 1'b0;
            st_d.excn    = '0;
        end
        if (spec_acc && st_q.unpriv && !st_q.handler)
            st_d.fault = 1'b1;
        // New masks and stack choice only bite once the writing instruction is done
        if (instr_boundary)
        begin
            st_d.act_prim = st_q.prim;
            st_d.act_fltm = st_q.fltm;
            st_d.act_bpri = st_q.bpri;
            st_d.act_psp  = st_q.unpriv && !st_q.handler;
        end
        if (st_q.dph_v && !st_q.dph_priv)
            st_d.fault = 1'b1;
        // Bus write lands last so software wins a same-cycle collision with the core
        if (ahb_we)
        begin
            unique case (st_q.dph_addr)
                CRF_OFF_PSW:
                begin
                    if (!hwdata[CRF_TBIT])
                        st_d.fault = 1'b1;
                    else
                    begin
                        st_d.flags = hwdata[CRF_FLAG_MSB:CRF_FLAG_LSB];
                        st_d.excn  = hwdata[CRF_EXCN_MSB:0];
                        st_d.exlo  = hwdata[CRF_EXLO_MSB:CRF_EXLO_LSB];
                        st_d.exhi  = hwdata[CRF_EXHI_MSB:CRF_EXHI_LSB];
                    end
                end
                CRF_OFF_FLAGS: st_d.flags = hwdata[CRF_FLAG_MSB:CRF_FLAG_LSB];
                CRF_OFF_EXCN:  st_d.excn  = hwdata[CRF_EXCN_MSB:0];
                CRF_OFF_EXEC:
                begin
                    if (!hwdata[CRF_TBIT])
                        st_d.fault = 1'b1;
                    else
                    begin
                        st_d.exlo = hwdata[CRF_EXLO_MSB:CRF_EXLO_LSB];
                        st_d.exhi = hwdata[CRF_EXHI_MSB:CRF_EXHI_LSB];
                    end
                end
                CRF_OFF_PRIM:  st_d.prim   = hwdata[0];
                CRF_OFF_FLTM:  st_d.fltm   = hwdata[0];
                CRF_OFF_BPRI:  st_d.bpri   = hwdata[8:0];
                CRF_OFF_MSP:   st_d.main_stack_ptr    = hwdata & CRF_SP_MASK;
                CRF_OFF_PSP:   st_d.process_stack_ptr    = hwdata & CRF_SP_MASK;
                CRF_OFF_CTRL:  st_d.unpriv = hwdata[0];
                CRF_OFF_LR:    st_d.lr     = hwdata;
                default:       st_d.lr     = st_d.lr;
            endcase
        end
        st_d.sp     = st_d.act_psp ? st_d.process_stack_ptr : st_d.main_stack_ptr;
        st_d.dph_v  = hsel && htrans[1] && hready;
        st_d.dph_wr = hwrite;
        st_d.dph_priv = hprot[1];
        st_d.dph_addr = haddr[7:0];
        st_d.hrdy   = 1'b1;
        // Read from the merged next state so a read right after a write sees it
        if (ahb_rd)
            st_d.hrd = hprot[1] ? bus_read(st_d, haddr[7:0]) : '0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q       <= '0;
            st_q.prim  <= CRF_MASK_RST;
            st_q.fltm  <= CRF_MASK_RST;
            st_q.bpri  <= CRF_BPRI_RST;
            st_q.main_stack_ptr   <= CRF_WORD_RST;
            st_q.hrdy  <= 1'b1;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign rd_a_data    = st_q.rda;
    assign rd_b_data    = st_q.rdb;
    assign sp_out       = st_q.sp;
    assign pc_out       = st_q.pc;
    assign handler_mode = st_q.handler;
    assign exc_accept   = st_q.accept;
    assign fault_pulse  = st_q.fault;
    assign hreadyout    = st_q.hrdy;
    assign hresp        = 1'b0;
    assign hrdata       = st_q.hrd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_sp_aligned: assert property (sp_out[1:0] == 2'b00)
        else $error("stack pointer not word aligned");
    a_pc_aligned: assert property (ce && pc_we |=> pc_out == ($past(pc_wdata) & CRF_PC_MASK))
        else $error("program counter not halfword aligned");
    a_tbit_fault: assert property (ce && ahb_we && !hwdata[CRF_TBIT]
                                   && (st_q.dph_addr == CRF_OFF_EXEC || st_q.dph_addr == CRF_OFF_PSW)
                                   |=> fault_pulse && $stable(st_q.exlo))
        else $error("clearing state bit did not fault");
    a_tbit_reads: assert property (ce && ahb_rd && hprot[1] && haddr[7:0] == CRF_OFF_PSW |=> hrdata[CRF_TBIT])
        else $error("state bit read as zero");
    a_lr_call: assert property (ce && call_en && !ahb_we |=> st_q.lr == $past(call_ret))
        else $error("return address not captured");
    a_nmi_pass: assert property (ce && irq.valid && irq.kind == CRF_KIND_NMI |=> exc_accept)
        else $error("non-maskable request was blocked");
    a_fault_mask: assert property (ce && st_q.act_fltm && irq.kind != CRF_KIND_NMI |=> !exc_accept)
        else $error("fault mask let a request through");
    a_prim_hard: assert property (ce && st_q.act_prim && !st_q.act_fltm && irq.valid
                                  && irq.kind == CRF_KIND_HARD |=> exc_accept)
        else $error("priority mask blocked hard fault");
    a_thr_block: assert property (ce && st_q.act_bpri != 9'h000 && irq.prio >= st_q.act_bpri
                                  |=> !exc_accept || $past(irq.kind) != CRF_KIND_OTHER)
        else $error("threshold failed to block");
    a_thr_off: assert property (ce && st_q.act_bpri == 9'h000 && !st_q.act_prim && !st_q.act_fltm
                                && irq.valid && irq.kind == CRF_KIND_OTHER |=> exc_accept)
        else $error("zero threshold still blocked");
    a_mask_reset: assert property ($rose(rstn) |-> !st_q.prim && !st_q.fltm && st_q.bpri == 9'h000)
        else $error("masks not clear after reset");
    a_act_hold: assert property (ce && !instr_boundary |=> $stable(st_q.act_bpri) && $stable(st_q.act_psp))
        else $error("mask copy changed between boundaries");
    a_unpriv_flt: assert property (ce && spec_acc && st_q.unpriv && !st_q.handler |=> fault_pulse)
        else $error("unprivileged access did not fault");
    a_psp_sel: assert property (ce && instr_boundary |=> st_q.act_psp == $past(st_q.unpriv && !st_q.handler))
        else $error("wrong stack pointer selected");
endmodule

// File: rtl/crf_pkg.sv
// Shared constants and carrier types of the core register file.
// Assumes one core clock domain; all users import crf_pkg::*.
package crf_pkg;
    localparam int unsigned CRF_XLEN      = 32;
    localparam int unsigned CRF_IDX_W     = 4;
    localparam int unsigned CRF_NGPR      = 13;
    localparam int unsigned CRF_PRIO_W    = 9;
    localparam int unsigned CRF_IDX_SP    = 13;
    localparam int unsigned CRF_IDX_LR    = 14;
    localparam int unsigned CRF_IDX_PC    = 15;
    // Register offsets (byte addresses, low address byte)
    localparam logic [7:0] CRF_OFF_PSW    = 8'h00;
    localparam logic [7:0] CRF_OFF_FLAGS  = 8'h04;
    localparam logic [7:0] CRF_OFF_EXCN   = 8'h08;
    localparam logic [7:0] CRF_OFF_EXEC   = 8'h0C;
    localparam logic [7:0] CRF_OFF_PRIM   = 8'h10;
    localparam logic [7:0] CRF_OFF_FLTM   = 8'h14;
    localparam logic [7:0] CRF_OFF_BPRI   = 8'h18;
    localparam logic [7:0] CRF_OFF_MSP    = 8'h1C;
    localparam logic [7:0] CRF_OFF_PSP    = 8'h20;
    localparam logic [7:0] CRF_OFF_CTRL   = 8'h24;
    localparam logic [7:0] CRF_OFF_LR     = 8'h28;
    localparam logic [7:0] CRF_OFF_PC     = 8'h2C;
    // Status word field positions
    localparam int unsigned CRF_FLAG_LSB  = 27;
    localparam int unsigned CRF_FLAG_MSB  = 31;
    localparam int unsigned CRF_EXCN_MSB  = 8;
    localparam int unsigned CRF_EXLO_LSB  = 10;
    localparam int unsigned CRF_EXLO_MSB  = 15;
    localparam int unsigned CRF_EXHI_LSB  = 25;
    localparam int unsigned CRF_EXHI_MSB  = 26;
    localparam int unsigned CRF_TBIT      = 24;
    localparam logic [31:0] CRF_VIEW_FLAGS = 32'hF800_0000;
    localparam logic [31:0] CRF_VIEW_EXCN  = 32'h0000_01FF;
    localparam logic [31:0] CRF_VIEW_EXEC  = 32'h0700_FC00;
    localparam logic [31:0] CRF_SP_MASK    = 32'hFFFF_FFFC;
    localparam logic [31:0] CRF_PC_MASK    = 32'hFFFF_FFFE;
    // Reset values
    localparam logic [31:0] CRF_WORD_RST   = 32'h0000_0000;
    localparam logic        CRF_MASK_RST   = 1'b0;
    localparam logic [8:0]  CRF_BPRI_RST   = 9'h000;

    typedef enum logic [1:0] {
        CRF_KIND_NMI   = 2'b00,
        CRF_KIND_HARD  = 2'b01,
        CRF_KIND_OTHER = 2'b10
    } crf_kind_e;

    typedef struct packed {
        logic                  valid;
        crf_kind_e             kind;
        logic [CRF_PRIO_W-1:0] prio;
    } crf_irq_s;

    typedef struct packed {
        logic                 en;
        logic [CRF_IDX_W-1:0] idx;
        logic [CRF_XLEN-1:0]  data;
    } crf_gwr_s;

    typedef struct packed {
        logic                 narrow;
        logic [CRF_IDX_W-1:0] idx;
    } crf_rd_s;
endpackage

// File: rtl/crf_gpr_bank.sv
// Flip-flop bank of the plain operand registers, one write and two read ports.
// Assumes indices are already narrowed by the caller; reads are combinational.
`timescale 1ns/10ps
module crf_gpr_bank
    import crf_pkg::*;
#(
    parameter int unsigned NREG = CRF_NGPR,
    parameter int unsigned W    = CRF_XLEN
)(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire crf_gwr_s             wr,
    input  wire logic [CRF_IDX_W-1:0] ra_idx,
    input  wire logic [CRF_IDX_W-1:0] rb_idx,
    output logic      [W-1:0]         ra_data,
    output logic      [W-1:0]         rb_data
);
    typedef struct packed {
        logic [NREG-1:0][W-1:0] r;
    } crf_bank_s;

    crf_bank_s st_q;
    crf_bank_s st_d;

    always_comb
    begin
        st_d = st_q;
        if (wr.en && (32'(wr.idx) < NREG))
        begin
            st_d.r[wr.idx] = wr.data;
        end
    end

    always_comb
    begin
        ra_data = (32'(ra_idx) < NREG) ? st_q.r[ra_idx] : '0;
        rb_data = (32'(rb_idx) < NREG) ? st_q.r[rb_idx] : '0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end
endmodule

// File: rtl/crf_mask_gate.sv
// Exception acceptance gate from the two mask bits and the priority threshold.
// Assumes mask inputs are the copies already in force at an instruction boundary.
`timescale 1ns/10ps
module crf_mask_gate
    import crf_pkg::*;
(
    input  wire logic                  prim,
    input  wire logic                  fltm,
    input  wire logic [CRF_PRIO_W-1:0] bpri,
    input  wire crf_irq_s              irq,
    output logic                       take
);
    logic thr_ok;

    always_comb
    begin
        // Zero threshold disables masking; lower value is more urgent
        thr_ok = (bpri == '0) || (irq.prio < bpri);
        take   = 1'b0;
        unique case (irq.kind)
            CRF_KIND_NMI:   take = irq.valid;
            CRF_KIND_HARD:  take = irq.valid && !fltm;
            CRF_KIND_OTHER: take = irq.valid && !fltm && !prim && thr_ok;
            default:        take = 1'b0;
        endcase
    end
endmodule

// File: verif/crf_core_regs_tb_top.sv
// Self-checking bench for the core register file: bus window, core ports, masking.
// Assumes crf_pkg and the design modules are compiled first; one 40 MHz clock.
`timescale 1ns/10ps
module crf_core_regs_tb_top
    import crf_pkg::*;
;
    logic        clk, rstn, ce, gwr_narrow, call_en, pc_we, flag_we, exc_entry, exc_return;
    logic        instr_boundary, spec_acc, hsel, hwrite, handler_mode, exc_accept, fault_pulse;
    logic        hreadyout, hresp;
    logic [31:0] call_ret, pc_wdata, haddr, hwdata, rd_a_data, rd_b_data, sp_out, pc_out, hrdata, rv;
    logic [4:0]  flag_in;
    logic [8:0]  exc_num;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  hprot;
    crf_rd_s     rd_a, rd_b;
    crf_gwr_s    gwr;
    crf_irq_s    irq;
    int          fails, cmp_count, faults;

    crf_core_regs u_dut (.clk(clk), .rstn(rstn), .ce(ce), .rd_a(rd_a), .rd_b(rd_b), .gwr(gwr),
        .gwr_narrow(gwr_narrow), .call_en(call_en), .call_ret(call_ret), .pc_we(pc_we),
        .pc_wdata(pc_wdata), .flag_we(flag_we), .flag_in(flag_in), .exc_entry(exc_entry),
        .exc_num(exc_num), .exc_return(exc_return), .instr_boundary(instr_boundary),
        .spec_acc(spec_acc), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
        .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .sp_out(sp_out), .pc_out(pc_out),
        .handler_mode(handler_mode), .exc_accept(exc_accept), .fault_pulse(fault_pulse),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    always #12.5 clk = ~clk;

    // Counted at the edge so each one-cycle pulse is seen exactly once
    always @(posedge clk)
        if (fault_pulse === 1'b1)
            faults++;

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Single word transfer; waits on hready in both phases, ends just after the data edge
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic pr);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        hprot <= {2'b00, pr, 1'b1};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rv = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask

    task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 1'b1);
        chk(nm, e, rv);
    endtask

    task automatic boundary();
        instr_boundary <= 1'b1;
        @(posedge clk);
        instr_boundary <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Irq is held across two edges so its acceptance has settled when looked at
    task automatic take(crf_kind_e k, logic [8:0] p, logic e);
        irq <= '{1'b1, k, p};
        repeat (2) @(posedge clk);
        #1;
        chk("exc_accept", {31'h0, e}, {31'h0, exc_accept});
    endtask

    task automatic t_reset();
        rchk("prim", CRF_OFF_PRIM, 32'h0000_0000);
        rchk("fltm", CRF_OFF_FLTM, 32'h0000_0000);
        rchk("bpri", CRF_OFF_BPRI, 32'h0000_0000);
        rchk("psw", CRF_OFF_PSW, 32'h0100_0000);
        $display("reset test done");
    endtask

    task automatic t_psw();
        int f;
        wr(CRF_OFF_FLAGS, 32'hFFFF_FFFF);
        rchk("flags", CRF_OFF_FLAGS, 32'hF800_0000);
        wr(CRF_OFF_EXCN, 32'h0000_0FFF);
        rchk("excn", CRF_OFF_EXCN, 32'h0000_01FF);
        wr(CRF_OFF_EXEC, 32'hFFFF_FFFF);
        rchk("exec", CRF_OFF_EXEC, 32'h0700_FC00);
        rchk("psw", CRF_OFF_PSW, 32'hFF00_FDFF);
        f = faults;
        wr(CRF_OFF_PSW, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1;
        chk("faults", f + 1, faults);
        rchk("psw", CRF_OFF_PSW, 32'hFF00_FDFF);
        wr(CRF_OFF_PSW, 32'h0100_0000);
        flag_in <= 5'b01010;
        flag_we <= 1'b1;
        @(posedge clk);
        flag_we <= 1'b0;
        rchk("flags", CRF_OFF_FLAGS, 32'h5000_0000);
        $display("status word test done");
    endtask

    task automatic t_gpr();
        for (int i = 0; i < 13; i++)
        begin
            gwr <= '{1'b1, 4'(i), 32'hA000_0000 + 32'(i)};
            @(posedge clk);
        end
        gwr.en <= 1'b0;
        for (int i = 0; i < 13; i++)
        begin
            rd_a <= '{1'b0, 4'(i)};
            @(posedge clk);
            #1;
            chk("rd_a", 32'hA000_0000 + 32'(i), rd_a_data);
        end
        rd_a <= '{1'b0, 4'd10};
        rd_b <= '{1'b1, 4'd10};
        @(posedge clk);
        #1;
        chk("rd_a", 32'hA000_000A, rd_a_data);
        chk("rd_b", 32'hA000_0002, rd_b_data);
        gwr_narrow <= 1'b1;
        gwr <= '{1'b1, 4'd11, 32'h5555_0000};
        @(posedge clk);
        gwr.en <= 1'b0;
        gwr_narrow <= 1'b0;
        rd_a <= '{1'b0, 4'd3};
        rd_b <= '{1'b0, 4'd11};
        repeat (2) @(posedge clk);
        #1;
        chk("rd_a", 32'h5555_0000, rd_a_data);
        chk("rd_b", 32'hA000_000B, rd_b_data);
        $display("general register test done");
    endtask

    task automatic t_spec();
        int f;
        wr(CRF_OFF_MSP, 32'h1234_5677);
        wr(CRF_OFF_PSP, 32'hAAAA_AAAB);
        boundary();
        chk("sp", 32'h1234_5674, sp_out);
        wr(CRF_OFF_CTRL, 32'h0000_0001);
        chk("sp", 32'h1234_5674, sp_out);
        boundary();
        chk("sp", 32'hAAAA_AAA8, sp_out);
        f = faults;
        spec_acc <= 1'b1;
        @(posedge clk);
        spec_acc <= 1'b0;
        bus(1'b1, CRF_OFF_PRIM, 32'h0000_0001, 1'b0);
        repeat (2) @(posedge clk);
        chk("faults", f + 2, faults);
        rchk("prim", CRF_OFF_PRIM, 32'h0000_0000);
        exc_num <= 9'h011;
        exc_entry <= 1'b1;
        @(posedge clk);
        exc_entry <= 1'b0;
        boundary();
        chk("mode", 32'h0000_0001, {31'h0, handler_mode});
        chk("sp", 32'h1234_5674, sp_out);
        rchk("excn", CRF_OFF_EXCN, 32'h0000_0011);
        f = faults;
        spec_acc <= 1'b1;
        @(posedge clk);
        spec_acc <= 1'b0;
        exc_return <= 1'b1;
        @(posedge clk);
        exc_return <= 1'b0;
        boundary();
        chk("faults", f, faults);
        chk("mode", 32'h0000_0000, {31'h0, handler_mode});
        chk("sp", 32'hAAAA_AAA8, sp_out);
        wr(CRF_OFF_CTRL, 32'h0000_0000);
        call_ret <= 32'h0000_2345;
        call_en <= 1'b1;
        pc_wdata <= 32'h0000_1001;
        pc_we <= 1'b1;
        gwr <= '{1'b1, 4'd13, 32'h0000_0107};
        @(posedge clk);
        call_en <= 1'b0;
        pc_we <= 1'b0;
        gwr.en <= 1'b0;
        rchk("lr", CRF_OFF_LR, 32'h0000_2345);
        rchk("pc", CRF_OFF_PC, 32'h0000_1000);
        chk("pc_out", 32'h0000_1000, pc_out);
        chk("sp", 32'h0000_0104, sp_out);
        ce <= 1'b0;
        pc_wdata <= 32'h0000_3000;
        pc_we <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        pc_we <= 1'b0;
        @(posedge clk);
        #1;
        chk("pc_out", 32'h0000_1000, pc_out);
        $display("special register test done");
    endtask

    task automatic t_mask();
        take(CRF_KIND_OTHER, 9'd5, 1'b1);
        wr(CRF_OFF_BPRI, 32'h0000_0005);
        take(CRF_KIND_OTHER, 9'd5, 1'b1);
        boundary();
        take(CRF_KIND_OTHER, 9'd5, 1'b0);
        take(CRF_KIND_OTHER, 9'd6, 1'b0);
        take(CRF_KIND_OTHER, 9'd4, 1'b1);
        wr(CRF_OFF_PRIM, 32'h0000_0001);
        boundary();
        take(CRF_KIND_OTHER, 9'd1, 1'b0);
        take(CRF_KIND_HARD, 9'd0, 1'b1);
        wr(CRF_OFF_FLTM, 32'h0000_0001);
        boundary();
        take(CRF_KIND_HARD, 9'd0, 1'b0);
        take(CRF_KIND_NMI, 9'd0, 1'b1);
        wr(CRF_OFF_PRIM, 32'h0000_0000);
        wr(CRF_OFF_FLTM, 32'h0000_0000);
        wr(CRF_OFF_BPRI, 32'h0000_0000);
        boundary();
        take(CRF_KIND_OTHER, 9'h1FF, 1'b1);
        irq <= '0;
        $display("masking test done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        {rstn, gwr_narrow, call_en, pc_we, flag_we, exc_entry, exc_return, instr_boundary} = 0;
        {spec_acc, hsel, hwrite, htrans, hprot, call_ret, pc_wdata, haddr, hwdata} = 0;
        {flag_in, exc_num, rd_a, rd_b, gwr, irq} = 0;
        clk = 1'b0;
        ce = 1'b1;
        hsize = 3'b010;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_psw();
        t_gpr();
        t_spec();
        t_mask();
        summarize();
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule
